// ==== hw/reg_ctrl_pkg.sv ====
// constants for the regulator control register bank
// assumes a 10 MHz ref_clk and 32-bit apb word addressing
package reg_ctrl_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BLANK_LONG_US = 1000;
  localparam int unsigned BLANK_SHORT_US = 25;
  localparam int unsigned BLANK_LONG_CYC = BLANK_LONG_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BLANK_SHORT_CYC = BLANK_SHORT_US * (CLK_HZ / 1_000_000);
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] IRQ_STAT_OFF = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h00C;
  localparam int AUX_LSB = 6;
  localparam int CAN_LSB = 3;
  localparam int BAL_EN_BIT = 2;
  localparam int BAL_AUTO_BIT = 1;
  localparam int VOFF_EN_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] SUP_OFF = 2'b00;
  localparam logic [1:0] SUP_QUIET = 2'b01;
  localparam logic [1:0] SUP_LONG = 2'b10;
  localparam logic [1:0] SUP_SHORT = 2'b11;
  // interrupt/status bit positions
  localparam int EV_AUX_UV = 0;
  localparam int EV_AUX_OC = 1;
  localparam int EV_AUX_SHUT = 2;
  localparam int EV_CAN_UV = 3;
  localparam int EV_CAN_OC = 4;
  localparam int EV_CAN_SHUT = 5;
  localparam int EV_LP_REFUSED = 6;
  localparam int EV_W = 7;
endpackage

// ==== hw/supply_supervisor.sv ====
// one regulator supervisor: enable, flag reporting and blanked shutdown
// assumes fault inputs already synchronised to ref_clk
`timescale 1ns/1ps
module supply_supervisor #(
  parameter int unsigned LONG_CYC = reg_ctrl_pkg::BLANK_LONG_CYC,
  parameter int unsigned SHORT_CYC = reg_ctrl_pkg::BLANK_SHORT_CYC
)(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [1:0] mode,
  input wire logic uv,
  input wire logic oc,
  output logic reg_en,
  output logic uv_evt,
  output logic oc_evt,
  output logic shut_evt
);
  logic [15:0] cnt_q;
  logic tripped_q;
  logic fault;
  logic [15:0] limit;
  logic uv_q;
  logic oc_q;

  assign fault = uv | oc;
  assign limit = (mode == reg_ctrl_pkg::SUP_SHORT) ? 16'(SHORT_CYC) : 16'(LONG_CYC);
  // code 00 keeps the regulator off; a blanked fault latches it off
  assign reg_en = (mode != reg_ctrl_pkg::SUP_OFF) && !tripped_q;

  // ------------------------------------------------------------
  // blanking counter
  // ------------------------------------------------------------
  // blanked shutdown
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_q <= 16'h0000;
    else if (!fault || !reg_en)
      cnt_q <= 16'h0000;
    else if (cnt_q < limit)
      cnt_q <= cnt_q + 16'h0001;
  end

  // off clears the trip, so software rewrites the field to retry
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      tripped_q <= 1'b0;
    else if (mode == reg_ctrl_pkg::SUP_OFF)
      tripped_q <= 1'b0;
    else if (fault && reg_en && cnt_q >= limit - 16'h0001)
      tripped_q <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      uv_q <= 1'b0;
      oc_q <= 1'b0;
    end
    else
    begin
      uv_q <= uv;
      oc_q <= oc;
    end
  end

  assign uv_evt = uv && !uv_q && reg_en && (mode[1] == 1'b1);
  assign oc_evt = oc && !oc_q && reg_en && (mode[1] == 1'b1);
  assign shut_evt = fault && reg_en && cnt_q >= limit - 16'h0001;
endmodule

// ==== hw/regulator_control_bits.sv ====
// regulator control bank: apb slave, two supervised regulators, pass transistor
// and low-power permit; fault and current inputs come from analog pins
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
module regulator_control_bits #(
  parameter int unsigned LONG_CYC = reg_ctrl_pkg::BLANK_LONG_CYC,
  parameter int unsigned SHORT_CYC = reg_ctrl_pkg::BLANK_SHORT_CYC
)(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic aux_uv,
  input wire logic aux_oc,
  input wire logic can_uv,
  input wire logic can_oc,
  input wire logic main_current_high,
  input wire logic low_power_request,
  output logic aux_regulator_on,
  output logic can_supply_on,
  output logic pass_transistor_on,
  output logic low_power_state,
  output logic irq
);
  logic [7:0] ctrl_q;
  logic [6:0] irq_stat_q;
  logic [6:0] irq_stat_d;
  logic [6:0] irq_mask_q;
  logic [31:0] prdata_q;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic lp_q;
  logic [6:0] events;
  logic wr;
  logic rd;
  logic addr_ok;
  logic aux_en;
  logic can_en;
  logic aux_uv_e;
  logic aux_oc_e;
  logic aux_sh_e;
  logic can_uv_e;
  logic can_oc_e;
  logic can_sh_e;
  logic lp_refused;
  logic access;
  logic wr_ctrl;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic [1:0] aux_mode;
  logic [1:0] can_mode;
  logic pass_force;
  logic pass_auto;
  logic lp_permit;
  logic aux_oc_s;
  logic can_uv_s;
  logic can_oc_s;
  logic current_high_s;
  logic lp_request_s;
  logic [3:0] status_word;
  logic [31:0] prdata_d;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == reg_ctrl_pkg::CTRL_OFF) || (a == reg_ctrl_pkg::STAT_OFF) ||
                (a == reg_ctrl_pkg::IRQ_STAT_OFF) || (a == reg_ctrl_pkg::IRQ_MASK_OFF);
  endfunction

  // every register strobe and the read mux go through this one compare
  function automatic logic hits(input logic [11:0] a, input logic [11:0] off);
    hits = (a == off);
  endfunction

  // ------------------------------------------------------------
  // apb access
  // ------------------------------------------------------------
  // zero wait states; unmapped addresses answer with pslverr
  assign addr_ok = is_mapped(paddr);
  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && !addr_ok;
  assign wr = access && pwrite && addr_ok;
  // reads decode in the setup cycle so prdata is already a flop in the access phase
  assign rd = psel && !penable && !pwrite;
  assign prdata = prdata_q;

  // ------------------------------------------------------------
  // write strobes
  // ------------------------------------------------------------
  assign wr_ctrl = wr && hits(paddr, reg_ctrl_pkg::CTRL_OFF);
  assign wr_irq_stat = wr && hits(paddr, reg_ctrl_pkg::IRQ_STAT_OFF);
  assign wr_irq_mask = wr && hits(paddr, reg_ctrl_pkg::IRQ_MASK_OFF);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end
    else
    begin
      sync1_q <= {low_power_request, main_current_high, can_oc, can_uv, aux_oc};
      sync2_q <= sync1_q;
    end
  end

  // aux_uv shares the same two-stage path through its own pair
  logic aux_uv_s1_q;
  logic aux_uv_s2_q;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aux_uv_s1_q <= 1'b0;
      aux_uv_s2_q <= 1'b0;
    end
    else
    begin
      aux_uv_s1_q <= aux_uv;
      aux_uv_s2_q <= aux_uv_s1_q;
    end
  end

  // ------------------------------------------------------------
  // synchronised pins
  // ------------------------------------------------------------
  // the comparators run free of ref_clk, so only second-stage flops are read below
  assign aux_oc_s = sync2_q[0];
  assign can_uv_s = sync2_q[1];
  assign can_oc_s = sync2_q[2];
  assign current_high_s = sync2_q[3];
  assign lp_request_s = sync2_q[4];

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  // reset clears fields
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_q <= reg_ctrl_pkg::CTRL_RESET;
    else if (wr_ctrl)
      // bit 5 is reserved and always reads zero
      ctrl_q <= {pwdata[7:6], 1'b0, pwdata[4:0]};
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_mask_q <= 7'h00;
    else if (wr_irq_mask)
      irq_mask_q <= pwdata[6:0];
  end

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  assign aux_mode = ctrl_q[reg_ctrl_pkg::AUX_LSB +: 2];
  assign can_mode = ctrl_q[reg_ctrl_pkg::CAN_LSB +: 2];
  assign pass_force = ctrl_q[reg_ctrl_pkg::BAL_EN_BIT];
  assign pass_auto = ctrl_q[reg_ctrl_pkg::BAL_AUTO_BIT];
  assign lp_permit = ctrl_q[reg_ctrl_pkg::VOFF_EN_BIT];

  // ------------------------------------------------------------
  // regulators
  // ------------------------------------------------------------
  // aux on/off
  supply_supervisor #(
    .LONG_CYC(LONG_CYC),
    .SHORT_CYC(SHORT_CYC)
  ) u_aux (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .mode(aux_mode),
    .uv(aux_uv_s2_q),
    .oc(aux_oc_s),
    .reg_en(aux_en),
    .uv_evt(aux_uv_e),
    .oc_evt(aux_oc_e),
    .shut_evt(aux_sh_e)
  );

  supply_supervisor #(
    .LONG_CYC(LONG_CYC),
    .SHORT_CYC(SHORT_CYC)
  ) u_can (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .mode(can_mode),
    .uv(can_uv_s),
    .oc(can_oc_s),
    .reg_en(can_en),
    .uv_evt(can_uv_e),
    .oc_evt(can_oc_e),
    .shut_evt(can_sh_e)
  );

  // outputs follow the supervisors, so a trip drops them in the same cycle
  assign aux_regulator_on = aux_en;
  assign can_supply_on = can_en;

  // ------------------------------------------------------------
  // pass transistor and low power
  // ------------------------------------------------------------
  // forced or automatic
  // the current level is only trusted after the pin synchroniser
  assign pass_transistor_on = pass_force || (pass_auto && current_high_s);

  // permit gate
  // a refused request keeps the main supply up and is reported every cycle it stands
  assign lp_refused = lp_request_s && !lp_permit && !lp_q;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      lp_q <= 1'b0;
    else
      lp_q <= lp_request_s && lp_permit;
  end
  assign low_power_state = lp_q;

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  // each event lands on its own status bit position
  always_comb
  begin
    events = 7'h00;
    events[reg_ctrl_pkg::EV_AUX_UV] = aux_uv_e;
    events[reg_ctrl_pkg::EV_AUX_OC] = aux_oc_e;
    events[reg_ctrl_pkg::EV_AUX_SHUT] = aux_sh_e;
    events[reg_ctrl_pkg::EV_CAN_UV] = can_uv_e;
    events[reg_ctrl_pkg::EV_CAN_OC] = can_oc_e;
    events[reg_ctrl_pkg::EV_CAN_SHUT] = can_sh_e;
    events[reg_ctrl_pkg::EV_LP_REFUSED] = lp_refused;
  end

  // a new event in the clearing cycle stays set
  always_comb
  begin
    irq_stat_d = irq_stat_q;
    if (wr_irq_stat)
      irq_stat_d = irq_stat_d & ~pwdata[6:0];
    irq_stat_d = irq_stat_d | events;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_stat_q <= 7'h00;
    else
      irq_stat_q <= irq_stat_d;
  end

  // level output: high while any unmasked sticky bit is set
  assign irq = |(irq_stat_q & irq_mask_q);

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  assign status_word = {pass_transistor_on, lp_q, can_en, aux_en};

  // unmapped reads return zero alongside pslverr
  always_comb
  begin
    prdata_d = 32'h0000_0000;
    if (hits(paddr, reg_ctrl_pkg::CTRL_OFF))
      prdata_d = {24'h00_0000, ctrl_q};
    else if (hits(paddr, reg_ctrl_pkg::STAT_OFF))
      prdata_d = {28'h000_0000, status_word};
    else if (hits(paddr, reg_ctrl_pkg::IRQ_STAT_OFF))
      prdata_d = {25'h000_0000, irq_stat_q};
    else if (hits(paddr, reg_ctrl_pkg::IRQ_MASK_OFF))
      prdata_d = {25'h000_0000, irq_mask_q};
  end

  // read data captured in the setup cycle so it is a flop in the access phase
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata_q <= 32'h0000_0000;
    else if (rd)
      prdata_q <= prdata_d;
  end
endmodule

// ==== tb/reg_ctrl_asserts.sv ====
// port checker for the regulator control bank
// assumes a bind onto regulator_control_bits; mirrors the control word
`timescale 1ns/1ps
module reg_ctrl_asserts #(
  parameter int unsigned LONG_CYC = 20,
  parameter int unsigned SHORT_CYC = 5
)(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic aux_uv,
  input wire logic aux_oc,
  input wire logic aux_regulator_on,
  input wire logic can_supply_on,
  input wire logic pass_transistor_on,
  input wire logic low_power_state
);
  logic [7:0] c_q;
  int unsigned f_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) c_q <= 8'h00;
    else if (psel && penable && pwrite && paddr == 12'h000) c_q <= pwdata[7:0];
  // fault age seen at the pins, before the design's two sync flops
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) f_q <= 0;
    else f_q <= (aux_uv || aux_oc) ? f_q + 1 : 0;
  reset_off_a: assert property (disable iff (1'b0) !reset_n |=> !aux_regulator_on && !can_supply_on)
    else $error("regulator on after reset");
  aux_off_a: assert property (c_q[7:6] == 2'b00 |-> !aux_regulator_on)
    else $error("aux on with field zero");
  can_off_a: assert property (c_q[4:3] == 2'b00 |-> !can_supply_on)
    else $error("can supply on with field zero");
  pass_force_a: assert property (c_q[2] |-> pass_transistor_on)
    else $error("pass transistor not forced");
  pass_idle_a: assert property (!c_q[2] && !c_q[1] |-> !pass_transistor_on)
    else $error("pass transistor on while disabled");
  lp_deny_a: assert property (!c_q[0] && !$past(c_q[0]) |-> !low_power_state)
    else $error("low power entered without permit");
  short_trip_a: assert property (c_q[7:6] == 2'b11 && f_q > SHORT_CYC + 4 |-> !aux_regulator_on)
    else $error("aux not shut after short blanking");
  long_trip_a: assert property ((c_q[7] ^ c_q[6]) && f_q > LONG_CYC + 4 |-> !aux_regulator_on)
    else $error("aux not shut after long blanking");
  blank_hold_a: assert property ((c_q[7] ^ c_q[6]) && f_q > 0 && f_q < LONG_CYC |-> aux_regulator_on)
    else $error("aux shut inside long blanking");
  cover property (c_q[7:6] == 2'b11 && f_q > SHORT_CYC + 4);
  cover property (low_power_state);
  cover property (pass_transistor_on && !c_q[2]);
endmodule
bind regulator_control_bits reg_ctrl_asserts #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) i_chk (.*);

// ==== tb/supply_pins.sv ====
// analog side stand-in: fault, current and low-power request pins
// assumes the bench sets want just after a rising edge
`timescale 1ns/1ps
module supply_pins (
  input wire logic ref_clk,
  input wire logic [5:0] want,
  output logic aux_uv,
  output logic aux_oc,
  output logic can_uv,
  output logic can_oc,
  output logic main_current_high,
  output logic low_power_request
);
  // pins follow one edge late, like slow comparators
  always_ff @(posedge ref_clk)
    {low_power_request, main_current_high, can_oc, can_uv, aux_oc, aux_uv} <= want;
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the regulator control bank
// assumes zero-wait apb answers and shortened blanking counts
`timescale 1ns/1ps
module tb;
  logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, aux_uv, aux_oc, can_uv, can_oc, main_current_high, low_power_request;
  logic aux_regulator_on, can_supply_on, pass_transistor_on, low_power_state, irq;
  logic [5:0] want = 6'h00;
  int n_fail = 0, compares = 0, cyc = 0;
  regulator_control_bits #(.LONG_CYC(20), .SHORT_CYC(5)) i_regulator_control_bits (.*);
  supply_pins i_supply_pins (.*);
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (++cyc > 5000)
    begin
      n_fail++;
      report_and_stop();
    end
  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask
  // rearm, set mode, hold a fault, then look at status and events
  task automatic trip(input logic [31:0] mode, input logic [5:0] pin, input int n,
                      input logic [31:0] st, input logic [31:0] ev, input logic [31:0] msk);
    apb(1, 12'h000, 32'h0000_0000);
    apb(1, 12'h008, 32'h0000_007F);
    apb(1, 12'h000, mode);
    want <= pin;
    tick(n);
    apb(0, 12'h004, 32'h0000_0000);
    chk(rd, st);
    apb(0, 12'h008, 32'h0000_0000);
    chk(rd & msk, ev);
    want <= 6'h00;
    tick(4);
  endtask
  initial
  begin
    tick(3);
    reset_n <= 1;
    tick(1);
    apb(0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (int m = 0; m < 4; m++)
    begin
      apb(1, 12'h000, 32'(m * 72));
      apb(0, 12'h004, 32'h0000_0000);
      chk(rd, (m != 0) ? 32'h0000_0003 : 32'h0000_0000);
    end
    apb(1, 12'h000, 32'h0000_0004);
    apb(0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    apb(1, 12'h000, 32'h0000_0002);
    apb(0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    want <= 6'h10;
    tick(4);
    apb(0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    apb(1, 12'h000, 32'h0000_0000);
    want <= 6'h20;
    tick(4);
    apb(0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1, 12'h00C, 32'h0000_0000);
    chk(irq, 1'b0);
    apb(1, 12'h00C, 32'h0000_0040);
    chk(irq, 1'b1);
    apb(1, 12'h000, 32'h0000_0001);
    tick(4);
    apb(0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    want <= 6'h00;
    apb(1, 12'h00C, 32'h0000_007F);
    trip(32'h0000_00C0, 6'h01, 13, 32'h0000_0000, 32'h0000_0005, 32'h0000_007F);
    trip(32'h0000_0080, 6'h02, 28, 32'h0000_0000, 32'h0000_0006, 32'h0000_007F);
    trip(32'h0000_0080, 6'h01, 15, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001);
    trip(32'h0000_0040, 6'h01, 28, 32'h0000_0000, 32'h0000_0000, 32'h0000_0003);
    trip(32'h0000_0010, 6'h08, 28, 32'h0000_0000, 32'h0000_0030, 32'h0000_0030);
    trip(32'h0000_0010, 6'h04, 15, 32'h0000_0002, 32'h0000_0008, 32'h0000_0008);
    apb(0, 12'h010, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    report_and_stop();
  end
endmodule
